// file: src/ccdfe_pkg.sv
package ccdfe_pkg;
   // serial word layout
   localparam int WORD_BITS  = 16;
   localparam int TEST_BIT   = 15;
   localparam int ADDR_HI    = 14;
   localparam int ADDR_LO    = 12;
   localparam int DATA_HI    = 11;
   localparam int DATA_LO    = 0;
   localparam int ADDR_BITS  = ADDR_HI - ADDR_LO + 1;
   localparam int DATA_BITS  = DATA_HI - DATA_LO + 1;

   // register codes
   localparam logic [2:0] ADDR_MODE     = 3'h0;
   localparam logic [2:0] ADDR_GAIN     = 3'h1;
   localparam logic [2:0] ADDR_BLACK    = 3'h2;
   localparam logic [2:0] ADDR_POLARITY = 3'h3;
   localparam logic [2:0] ADDR_FIRST    = 3'h4;
   localparam logic [2:0] ADDR_SECOND   = 3'h5;

   // field widths
   localparam int MODE_BITS  = 3;
   localparam int GAIN_BITS  = 10;
   localparam int BLACK_BITS = 4;
   localparam int POL_BITS   = 3;
   localparam int LEVEL_BITS = 8;
   localparam int PIXEL_BITS = 10;

   // field positions inside mode and polarity
   localparam int CORE_SLEEP_BIT   = 0;
   localparam int FIRST_SLEEP_BIT  = 1;
   localparam int SECOND_SLEEP_BIT = 2;
   localparam int DUMMY_POL_BIT    = 0;
   localparam int BLACK_POL_BIT    = 1;
   localparam int SAMPLE_POL_BIT   = 2;

   // reset values
   localparam logic [2:0] MODE_RESET     = 3'h0;
   localparam logic [9:0] GAIN_RESET     = 10'h080;
   localparam logic [3:0] BLACK_RESET    = 4'h8;
   localparam logic [2:0] POL_RESET      = 3'h0;
   localparam logic [7:0] LEVEL_RESET    = 8'h00;
   localparam logic [9:0] PIXEL_IDLE     = 10'h000;

   // transfer timing, in conversion clock cycles
   localparam int SYNC_STAGES  = 2;
   localparam int APPLY_CYCLES = 5;

   typedef enum logic [1:0] {
      XFER_IDLE  = 2'b00,
      XFER_HOLD  = 2'b01,
      XFER_APPLY = 2'b11
   } ccdfe_xfer_type;
endpackage : ccdfe_pkg

// file: src/ccdfe_sync.sv
`timescale 1ns/1ns
module ccdfe_sync #(
   parameter int WIDTH  = 1,
   parameter int STAGES = 2
) (
   // clock
   input  wire logic             clock,
   // data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage_q [STAGES];
   logic [WIDTH-1:0] stage_d [STAGES];

   if (STAGES < 2) begin : g_stages_short
      $error("ccdfe_sync needs at least two stages");
   end

   // first stage feeds only the next stage
   always_comb begin
      stage_d[0] = async_in;
      for (int i = 1; i < STAGES; i++) begin
         stage_d[i] = stage_q[i-1];
      end
   end

   always_ff @(posedge clock) begin
      stage_q <= stage_d;
   end

   assign sync_out = stage_q[STAGES-1];
endmodule : ccdfe_sync

// file: src/ccdfe_shifter.sv
`timescale 1ns/1ns
module ccdfe_shifter
   import ccdfe_pkg::*;
(
   // link side, clocked by the host's shift clock
   input  wire logic                 shift_clock,
   input  wire logic                 serial_load_strobe_n,
   input  wire logic                 serial_write_input,
   // shifted word, stable while the strobe is high
   output logic      [WORD_BITS-1:0] shift_word
);
   logic [WORD_BITS-1:0] shift_q;
   logic [WORD_BITS-1:0] shift_d;

   // RULE_18: low strobe shifts
   always_comb begin
      shift_d = shift_q;
      if (!serial_load_strobe_n) begin
         shift_d = {shift_q[WORD_BITS-2:0], serial_write_input};
      end
   end

   // data only; the clock may stop between frames, so no reset here
   always_ff @(posedge shift_clock) begin
      shift_q <= shift_d;
   end

   assign shift_word = shift_q;
endmodule : ccdfe_shifter

// file: src/ccdfe_control_registers.sv
// Contract
// RULE_01: first converter sleep bit one puts it in standby, zero keeps it active.
// RULE_02: second converter sleep bit one puts it in standby, zero keeps it active.
// RULE_03: ten-bit gain code held; reset value is the unity gain pattern.
// RULE_04: four-bit black clamp level held; reset value gives thirty-two LSB pedestal.
// RULE_05: dummy clamp pulse active low at polarity zero, active high at one.
// RULE_06: black clamp pulse active low at polarity zero, active high at one.
// RULE_07: both sampling pulses share one polarity bit, zero low, one high.
// RULE_08: first converter code eight bits, zeros minimum, ones maximum.
// RULE_09: second converter code eight bits, zeros minimum, ones maximum.
// RULE_10: contents unknown at power-on; host writes all or pulses reset for defaults.
// RULE_11: after reset mode field is zero, everything active.
// RULE_12: after reset all polarity bits zero, every pulse active low.
// RULE_13: after reset both converter codes are zero.
// RULE_14: core standby masks conversion clock, sampling and clamp pulses high.
// RULE_15: pixel output words update on the conversion clock.
// RULE_16: host avoids black clamp pulse while preblanking is active.
// RULE_17: black clamp pulse may stand in for a missing dummy clamp pulse.
// RULE_18: strobe low, sixteen bits on rising shift clock, strobe rise latches.
// RULE_19: word is test flag, three address bits, twelve data bits.
// RULE_20: latched word reaches its register five to six cycles after strobe rise.
// RULE_21: core standby leaves the serial port and registers writable.
// RULE_22: reserved codes or test flag set change no register.
// RULE_23: polarity change takes effect at the next edge after the update.
`timescale 1ns/1ns
module ccdfe_control_registers
   import ccdfe_pkg::*;
#(
   parameter int APPLY_DELAY = APPLY_CYCLES
) (
   // conversion clock domain
   input  wire logic                  clock,
   input  wire logic                  reset,
   // serial link
   input  wire logic                  shift_clock,
   input  wire logic                  serial_load_strobe_n,
   input  wire logic                  serial_write_input,
   // timing pulse pins
   input  wire logic                  dummy_pixel_clamp_pulse,
   input  wire logic                  optical_black_clamp_pulse,
   input  wire logic                  reference_sample_pulse,
   input  wire logic                  video_sample_pulse,
   input  wire logic                  preblanking_input,
   // converter core
   input  wire logic [PIXEL_BITS-1:0] pixel_code,
   output logic      [PIXEL_BITS-1:0] pixel_word,
   // mode outputs
   output logic                       core_sleep,
   output logic                       first_converter_sleep,
   output logic                       second_converter_sleep,
   output logic                       conversion_clock_masked,
   // setting outputs
   output logic      [GAIN_BITS-1:0]  amplifier_gain_setting,
   output logic      [BLACK_BITS-1:0] black_level_setting,
   output logic      [POL_BITS-1:0]   strobe_polarity_setting,
   output logic      [LEVEL_BITS-1:0] first_converter_level,
   output logic      [LEVEL_BITS-1:0] second_converter_level,
   // masked pulse lines and decoded activity
   output logic                       dummy_clamp_line,
   output logic                       black_clamp_line,
   output logic                       reference_sample_line,
   output logic                       video_sample_line,
   output logic                       dummy_clamp_active,
   output logic                       black_clamp_active,
   output logic                       reference_sample_active,
   output logic                       video_sample_active,
   output logic                       preblanking_active
);
   localparam int HOLD_LOAD = APPLY_DELAY - SYNC_STAGES - 2;

   // refused at elaboration: below five the hold counter cannot serve the delay, and above six cycles is refused too
   if (APPLY_DELAY < SYNC_STAGES + 3) begin : g_delay_short
      $error("APPLY_DELAY too short for the crossing");
   end
   if (APPLY_DELAY > 6) begin : g_delay_long
      $error("APPLY_DELAY beyond six cycles");
   end

   function automatic logic word_valid(input logic [WORD_BITS-1:0] w);
      return !w[TEST_BIT] && (w[ADDR_HI:ADDR_LO] <= ADDR_SECOND);
   endfunction : word_valid

   function automatic logic writes(input logic [WORD_BITS-1:0] w, input logic [2:0] a);
      return word_valid(w) && (w[ADDR_HI:ADDR_LO] == a);
   endfunction : writes

   function automatic logic pulse_on(input logic pin, input logic pol);
      return pin == pol;
   endfunction : pulse_on

   // link side
   logic [WORD_BITS-1:0] shift_word;
   ccdfe_shifter u_shifter (
      .shift_clock          (shift_clock),
      .serial_load_strobe_n (serial_load_strobe_n),
      .serial_write_input   (serial_write_input),
      .shift_word           (shift_word)
   );

   // strobe and timing pins cross into the conversion clock domain
   logic       strobe_sync;
   logic [4:0] pulse_sync;
   ccdfe_sync #(.WIDTH(1), .STAGES(SYNC_STAGES)) u_strobe_sync (
      .clock    (clock),
      .async_in (serial_load_strobe_n),
      .sync_out (strobe_sync)
   );
   ccdfe_sync #(.WIDTH(5), .STAGES(SYNC_STAGES)) u_pulse_sync (
      .clock    (clock),
      .async_in ({preblanking_input, video_sample_pulse, reference_sample_pulse,
                  optical_black_clamp_pulse, dummy_pixel_clamp_pulse}),
      .sync_out (pulse_sync)
   );

   // transfer state
   ccdfe_xfer_type       xfer_q, xfer_d;
   logic                 strobe_prev_q, strobe_prev_d;
   logic [2:0]           hold_q, hold_d;
   logic [WORD_BITS-1:0] latch_q, latch_d;
   logic                 strobe_rise;

   assign strobe_rise = strobe_sync && !strobe_prev_q;

   // RULE_20: crossing plus hold
   always_comb begin
      xfer_d        = xfer_q;
      hold_d        = hold_q;
      latch_d       = latch_q;
      strobe_prev_d = strobe_sync;
      case (xfer_q)
         XFER_IDLE: begin
            // RULE_18: latch on rise
            if (strobe_rise) begin
               latch_d = shift_word;
               hold_d  = 3'(HOLD_LOAD);
               xfer_d  = XFER_HOLD;
            end
         end
         XFER_HOLD: begin
            if (hold_q <= 3'h1) begin
               xfer_d = XFER_APPLY;
            end else begin
               hold_d = hold_q - 3'h1;
            end
         end
         XFER_APPLY: begin
            xfer_d = XFER_IDLE;
         end
         default: begin
            xfer_d = XFER_IDLE;
         end
      endcase
   end

   // shift word is quiet while the strobe is high, so sampling it after the
   // synchronised rise is safe without a word-wide crossing
   always_ff @(posedge clock) begin
      if (reset) begin
         xfer_q        <= XFER_IDLE;
         hold_q        <= 3'h0;
         latch_q       <= '0;
         strobe_prev_q <= 1'b1;
      end else begin
         xfer_q        <= xfer_d;
         hold_q        <= hold_d;
         latch_q       <= latch_d;
         strobe_prev_q <= strobe_prev_d;
      end
   end

   // user registers
   logic [MODE_BITS-1:0]  mode_q, mode_d;
   logic [GAIN_BITS-1:0]  gain_q, gain_d;
   logic [BLACK_BITS-1:0] black_q, black_d;
   logic [POL_BITS-1:0]   pol_q, pol_d;
   logic [LEVEL_BITS-1:0] first_q, first_d;
   logic [LEVEL_BITS-1:0] second_q, second_d;
   logic                  apply;

   assign apply = (xfer_q == XFER_APPLY);

   // RULE_19: field decode
   // RULE_21: writable in standby
   always_comb begin
      mode_d   = mode_q;
      gain_d   = gain_q;
      black_d  = black_q;
      pol_d    = pol_q;
      first_d  = first_q;
      second_d = second_q;
      // RULE_22: reserved words dropped
      if (apply && word_valid(latch_q)) begin
         if (writes(latch_q, ADDR_MODE))     mode_d   = latch_q[MODE_BITS-1:0];
         if (writes(latch_q, ADDR_GAIN))     gain_d   = latch_q[GAIN_BITS-1:0];
         if (writes(latch_q, ADDR_BLACK))    black_d  = latch_q[BLACK_BITS-1:0];
         if (writes(latch_q, ADDR_POLARITY)) pol_d    = latch_q[POL_BITS-1:0];
         // RULE_08: first code
         if (writes(latch_q, ADDR_FIRST))    first_d  = latch_q[LEVEL_BITS-1:0];
         // RULE_09: second code
         if (writes(latch_q, ADDR_SECOND))   second_d = latch_q[LEVEL_BITS-1:0];
      end
   end

   // RULE_10: reset loads defaults
   // RULE_03: unity gain default
   // RULE_04: black level default
   // RULE_11: mode default zero
   // RULE_12: polarity default zero
   // RULE_13: converter codes zero
   always_ff @(posedge clock) begin
      if (reset) begin
         mode_q   <= MODE_RESET;
         gain_q   <= GAIN_RESET;
         black_q  <= BLACK_RESET;
         pol_q    <= POL_RESET;
         first_q  <= LEVEL_RESET;
         second_q <= LEVEL_RESET;
      end else begin
         mode_q   <= mode_d;
         gain_q   <= gain_d;
         black_q  <= black_d;
         pol_q    <= pol_d;
         first_q  <= first_d;
         second_q <= second_d;
      end
   end

   // pulse handling and pixel output
   logic [3:0]            line_q, line_d;
   logic [4:0]            act_q, act_d;
   logic [PIXEL_BITS-1:0] pixel_q, pixel_d;
   logic                  sleeping;

   assign sleeping = mode_q[CORE_SLEEP_BIT];

   always_comb begin
      // RULE_14: standby forces lines high
      line_d  = sleeping ? 4'hF : pulse_sync[3:0];
      // RULE_23: registered polarity
      // RULE_05: dummy clamp polarity
      act_d[0] = !sleeping && pulse_on(pulse_sync[0], pol_q[DUMMY_POL_BIT]);
      // RULE_06: black clamp polarity
      act_d[1] = !sleeping && pulse_on(pulse_sync[1], pol_q[BLACK_POL_BIT]);
      // RULE_07: shared sampling polarity
      act_d[2] = !sleeping && pulse_on(pulse_sync[2], pol_q[SAMPLE_POL_BIT]);
      act_d[3] = !sleeping && pulse_on(pulse_sync[3], pol_q[SAMPLE_POL_BIT]);
      // preblanking pin is active low
      act_d[4] = !sleeping && !pulse_sync[4];
      // RULE_15: pixel word per edge
      pixel_d = sleeping ? PIXEL_IDLE : pixel_code;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         line_q  <= 4'hF;
         act_q   <= 5'h00;
         pixel_q <= PIXEL_IDLE;
      end else begin
         line_q  <= line_d;
         act_q   <= act_d;
         pixel_q <= pixel_d;
      end
   end

   // outputs
   // RULE_01: first converter standby
   assign first_converter_sleep   = mode_q[FIRST_SLEEP_BIT];
   // RULE_02: second converter standby
   assign second_converter_sleep  = mode_q[SECOND_SLEEP_BIT];
   assign core_sleep              = sleeping;
   // RULE_14: clock mask flag
   assign conversion_clock_masked = sleeping;
   assign amplifier_gain_setting  = gain_q;
   assign black_level_setting     = black_q;
   assign strobe_polarity_setting = pol_q;
   assign first_converter_level   = first_q;
   assign second_converter_level  = second_q;
   assign dummy_clamp_line        = line_q[0];
   assign black_clamp_line        = line_q[1];
   assign reference_sample_line   = line_q[2];
   assign video_sample_line       = line_q[3];
   assign dummy_clamp_active      = act_q[0];
   assign black_clamp_active      = act_q[1];
   assign reference_sample_active = act_q[2];
   assign video_sample_active     = act_q[3];
   assign preblanking_active      = act_q[4];
   assign pixel_word              = pixel_q;

   // checks
   reset_defaults_a: assert property (@(posedge clock) // RULE_03
      reset |=> gain_q == GAIN_RESET && black_q == BLACK_RESET)
      else $error("gain or black level not at default after reset");

   reset_modes_a: assert property (@(posedge clock) // RULE_11
      reset |=> mode_q == MODE_RESET && pol_q == POL_RESET
                      && first_q == LEVEL_RESET && second_q == LEVEL_RESET)
      else $error("mode, polarity or converter code not cleared by reset");

   apply_latency_a: assert property (@(posedge clock) disable iff (reset) // RULE_20
      xfer_q == XFER_IDLE && strobe_rise |=> xfer_q == XFER_HOLD ##1 xfer_q == XFER_APPLY)
      else $error("latched word not applied on time");

   strobe_to_apply_a: assert property (@(posedge clock) disable iff (reset) // RULE_20
      $rose(strobe_sync) && !$past(reset) && xfer_q == XFER_IDLE |-> ##2 apply)
      else $error("apply not two cycles after synchronised strobe rise");

   reserved_ignored_a: assert property (@(posedge clock) disable iff (reset) // RULE_22
      apply && !word_valid(latch_q) |=> $stable({mode_q, gain_q, black_q, pol_q,
                                                  first_q, second_q}))
      else $error("reserved word changed a register");

   gain_written_a: assert property (@(posedge clock) disable iff (reset) // RULE_03
      apply && writes(latch_q, ADDR_GAIN) |=> gain_q == $past(latch_q[GAIN_BITS-1:0]))
      else $error("gain write lost");

   converter_sleep_a: assert property (@(posedge clock) disable iff (reset) // RULE_01
      apply && writes(latch_q, ADDR_MODE) |=>
         first_converter_sleep == $past(latch_q[FIRST_SLEEP_BIT])
         && second_converter_sleep == $past(latch_q[SECOND_SLEEP_BIT]))
      else $error("converter sleep bits not taken from mode write");

   standby_mask_a: assert property (@(posedge clock) disable iff (reset) // RULE_14
      $past(sleeping) && !$past(reset) |-> line_q == 4'hF && pixel_q == PIXEL_IDLE
                                          && act_q == 5'h00)
      else $error("pulses or pixels not masked in standby");

   black_polarity_a: assert property (@(posedge clock) disable iff (reset) // RULE_06
      !$past(sleeping) && !$past(reset) |->
         black_clamp_active == ($past(pulse_sync[1]) == $past(pol_q[1])))
      else $error("black clamp polarity misread");

   sample_polarity_a: assert property (@(posedge clock) disable iff (reset) // RULE_07
      !$past(sleeping) && !$past(reset) |->
         video_sample_active == ($past(pulse_sync[3]) == $past(pol_q[2])))
      else $error("sampling polarity misread");
endmodule : ccdfe_control_registers

// file: dv/ccdfe_host_model.sv
`timescale 1ns/1ns
module ccdfe_host_model
   import ccdfe_pkg::*;
(
   // serial link pins
   output logic shift_clock,
   output logic serial_load_strobe_n,
   output logic serial_write_input
);
   initial begin
      shift_clock          = 1'b0;
      serial_load_strobe_n = 1'b1;
      serial_write_input   = 1'b0;
   end

   // 48 ns shift clock, runs only inside a frame
   // msb first frame
   task automatic send_word(input logic [WORD_BITS-1:0] word);
      int i;
      serial_load_strobe_n = 1'b0;
      for (i = WORD_BITS - 1; i >= 0; i--) begin
         serial_write_input = word[i];
         #12;
         shift_clock = 1'b1;
         #24;
         shift_clock = 1'b0;
         #12;
      end
      serial_load_strobe_n = 1'b1;
      // released line flips so a stale bit never looks valid
      serial_write_input = ~serial_write_input;
   endtask : send_word
endmodule : ccdfe_host_model

// file: dv/ccd_frontend_control_registers_tb.sv
`timescale 1ns/1ns
module ccd_frontend_control_registers_tb
   import ccdfe_pkg::*;
;
   logic        clock = 1'b0;
   logic        reset = 1'b1;
   logic        dummy_pixel_clamp_pulse = 1'b1;
   logic        optical_black_clamp_pulse = 1'b1;
   logic        reference_sample_pulse = 1'b1;
   logic        video_sample_pulse = 1'b1;
   logic        preblanking_input = 1'b1;
   logic [9:0]  pixel_code = 10'h000;
   logic        shift_clock, serial_load_strobe_n, serial_write_input;
   logic [9:0]  pixel_word, amplifier_gain_setting;
   logic        core_sleep, first_converter_sleep, second_converter_sleep;
   logic        conversion_clock_masked;
   logic [3:0]  black_level_setting;
   logic [2:0]  strobe_polarity_setting;
   logic [7:0]  first_converter_level, second_converter_level;
   logic        dummy_clamp_line, black_clamp_line, reference_sample_line;
   logic        video_sample_line, dummy_clamp_active, black_clamp_active;
   logic        reference_sample_active, video_sample_active, preblanking_active;
   logic [35:0] regs_now, expected_regs;
   logic [9:0]  pulse_now;
   logic [3:0]  exp_active;
   int          mismatches = 0;
   int          tests_run = 0;
   int          cycles = 0;
   int          m, lv;

   assign regs_now = {second_converter_sleep, first_converter_sleep, core_sleep,
                      amplifier_gain_setting, black_level_setting, strobe_polarity_setting,
                      first_converter_level, second_converter_level};
   assign pulse_now = {dummy_clamp_line, black_clamp_line, reference_sample_line,
                       video_sample_line, dummy_clamp_active, black_clamp_active,
                       reference_sample_active, video_sample_active, preblanking_active,
                       conversion_clock_masked};

   ccdfe_host_model host_u (
      .shift_clock          (shift_clock),
      .serial_load_strobe_n (serial_load_strobe_n),
      .serial_write_input   (serial_write_input)
   );

   ccdfe_control_registers #(.APPLY_DELAY(APPLY_CYCLES)) dut_u (
      .clock(clock), .reset(reset), .shift_clock(shift_clock),
      .serial_load_strobe_n(serial_load_strobe_n), .serial_write_input(serial_write_input),
      .dummy_pixel_clamp_pulse(dummy_pixel_clamp_pulse),
      .optical_black_clamp_pulse(optical_black_clamp_pulse),
      .reference_sample_pulse(reference_sample_pulse), .video_sample_pulse(video_sample_pulse),
      .preblanking_input(preblanking_input), .pixel_code(pixel_code), .pixel_word(pixel_word),
      .core_sleep(core_sleep), .first_converter_sleep(first_converter_sleep),
      .second_converter_sleep(second_converter_sleep),
      .conversion_clock_masked(conversion_clock_masked),
      .amplifier_gain_setting(amplifier_gain_setting), .black_level_setting(black_level_setting),
      .strobe_polarity_setting(strobe_polarity_setting),
      .first_converter_level(first_converter_level),
      .second_converter_level(second_converter_level),
      .dummy_clamp_line(dummy_clamp_line), .black_clamp_line(black_clamp_line),
      .reference_sample_line(reference_sample_line), .video_sample_line(video_sample_line),
      .dummy_clamp_active(dummy_clamp_active), .black_clamp_active(black_clamp_active),
      .reference_sample_active(reference_sample_active),
      .video_sample_active(video_sample_active), .preblanking_active(preblanking_active)
   );

   always #10 clock = ~clock;

   task automatic finish_test();
      $display("Checks run %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   // a hung run counts as a mismatch
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         mismatches++;
         finish_test();
      end
   end

   task automatic check(input logic [35:0] seen, input logic [35:0] expect_v);
      tests_run++;
      if (seen !== expect_v) begin
         mismatches++;
         $display("Error at %0t ns: saw %h expected %h", $time, seen, expect_v);
      end
   endtask : check

   task automatic do_reset();
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
      expected_regs = {3'h0, 10'h080, 4'h8, 3'h0, 8'h00, 8'h00};
      check(regs_now, expected_regs);
      check(36'(pulse_now), 36'(10'b1111_0000_00));
   endtask : do_reset

   // frame starts 3 ns past an edge so the strobe rise falls between edges
   task automatic write_reg(input logic [2:0] addr, input logic [11:0] data, input logic tst);
      logic [35:0] old_regs;
      old_regs = expected_regs;
      if (!tst) begin
         case (addr)
            ADDR_MODE:     expected_regs[35:33] = data[2:0];
            ADDR_GAIN:     expected_regs[32:23] = data[9:0];
            ADDR_BLACK:    expected_regs[22:19] = data[3:0];
            ADDR_POLARITY: expected_regs[18:16] = data[2:0];
            ADDR_FIRST:    expected_regs[15:8] = data[7:0];
            ADDR_SECOND:   expected_regs[7:0] = data[7:0];
            default: ;
         endcase
      end
      @(posedge clock);
      #3;
      host_u.send_word({tst, addr, data});
      repeat (4) @(posedge clock);
      #1;
      check(regs_now, old_regs);
      repeat (2) @(posedge clock);
      #1;
      check(regs_now, expected_regs);
   endtask : write_reg

   // pins go through a two stage sync, so allow four edges
   task automatic set_pins(input logic [4:0] levels);
      @(posedge clock);
      {dummy_pixel_clamp_pulse, optical_black_clamp_pulse, reference_sample_pulse,
       video_sample_pulse, preblanking_input} <= levels;
      repeat (4) @(posedge clock);
      #1;
   endtask : set_pins

   initial begin
      do_reset();
      for (m = 0; m < 8; m++) begin
         write_reg(ADDR_MODE, 12'(m), 1'b0);
      end
      write_reg(ADDR_MODE, 12'h000, 1'b0);
      write_reg(ADDR_GAIN, 12'hEA5, 1'b0);
      write_reg(ADDR_BLACK, 12'hFF5, 1'b0);
      write_reg(ADDR_FIRST, 12'h0FF, 1'b0);
      write_reg(ADDR_SECOND, 12'h0A5, 1'b0);
      write_reg(ADDR_FIRST, 12'h000, 1'b0);
      write_reg(3'h6, 12'hFFF, 1'b0);
      write_reg(3'h7, 12'hFFF, 1'b0);
      write_reg(ADDR_GAIN, 12'h155, 1'b1);
      for (m = 0; m < 8; m++) begin
         write_reg(ADDR_POLARITY, 12'(m), 1'b0);
         for (lv = 0; lv < 2; lv++) begin
            set_pins({{4{1'(lv)}}, 1'b1});
            exp_active = {1'(lv) ~^ 1'(m), 1'(lv) ~^ 1'(m >> 1),
                          {2{1'(lv) ~^ 1'(m >> 2)}}};
            check(36'(pulse_now), 36'({{4{1'(lv)}}, exp_active, 2'b00}));
         end
      end
      set_pins(5'b11111);
      do_reset();
      set_pins(5'b11110);
      check(36'(pulse_now), 36'(10'b1111_0000_10));
      set_pins(5'b10111);
      check(36'(pulse_now), 36'(10'b1011_0100_00));
      write_reg(ADDR_MODE, 12'h001, 1'b0);
      pixel_code <= 10'h3A5;
      set_pins(5'b00001);
      check(36'(pulse_now), 36'(10'b1111_0000_01));
      check(36'(pixel_word), 36'(10'h000));
      write_reg(ADDR_GAIN, 12'h3FF, 1'b0);
      write_reg(ADDR_MODE, 12'h000, 1'b0);
      repeat (2) @(posedge clock);
      #1;
      check(36'(pulse_now), 36'(10'b0000_1111_00));
      @(posedge clock);
      pixel_code <= 10'h155;
      @(posedge clock);
      #1;
      check(36'(pixel_word), 36'(10'h155));
      set_pins(5'b11111);
      do_reset();
      finish_test();
   end
endmodule : ccd_frontend_control_registers_tb
